// *** rtl/abs_readout_pkg.sv ***
// Shared constants for the absolute position readout link
package abs_readout_pkg;
  localparam int          FRAME_BITS      = 56;
  localparam int          POS_BITS        = 32;
  localparam int          BYTE_BITS       = 8;
  localparam int          PAIR_COUNT      = FRAME_BITS / 2;
  localparam int          PAIR_CNT_W      = 5;
  localparam int          BIT_CNT_W       = 6;
  localparam int          CLK_MHZ         = 200;
  localparam int          READY_MAX_US    = 2000;
  localparam int          READY_MAX_CYC   = (READY_MAX_US * CLK_MHZ);
  localparam int          FILTER_LEN      = 4;
  localparam int          FILTER_CNT_W    = 3;
  localparam logic [7:0]  STATUS_OVERFLOW = 8'h01;
  localparam logic        RESET_MODE_REQ  = 1'b0;
  localparam logic        RESET_MODE_NOW  = 1'b1;
  localparam int          HOST_DIV        = 16;
  localparam int          HOST_DIV_W      = 5;
  localparam logic [4:0]  HOST_DIV_LAST   = 5'h0f;
endpackage

// *** rtl/abs_readout_if.sv ***
// Pin bundle between the servo driver end and the controller end
`timescale 1ns/1ps
interface abs_readout_if;
  logic positionRequest;
  logic handshakeClock;
  logic dataReady;
  logic dataLow;
  logic dataHigh;
  modport device (
    input  positionRequest,
    input  handshakeClock,
    output dataReady,
    output dataLow,
    output dataHigh
  );
  modport host (
    output positionRequest,
    output handshakeClock,
    input  dataReady,
    input  dataLow,
    input  dataHigh
  );
endinterface

// *** rtl/abs_readout_device.sv ***
// Servo driver end: position recovery logic and 56-bit readout sender
`timescale 1ns/1ps
// Function
// - Alarm stays reported until home preset
// - Alarm clear zeroes the position counter
// - Act on alarm clear then home preset
// - Power cycle before home re-raises alarm
// - Mode 0 enables pulses on request rise
// - Mode 1 enables pulses at alarm clear
// - Readout only with absolute function enabled
// - Frame is position, status, alarm, checksum
// - Position sent in two's complement
// - Checksum is low byte of six-byte sum
// - Status bit0 overflow; alarm code binary
// - Request repurposes shared pins for handshake
// - Low bit first output, high second; code sends frame bit 55 first on dataHigh, with bit 54 on dataLow
// - Request honoured at any time
// - Ready within 2 ms of request rise
// - Controller raises clock after ready seen
// - On clock high, shift pair, drop ready
// - Controller samples then lowers clock
// - Clock low raises ready; 28 pairs
// - Controller drops request after 56 bits
// - Request low restores normal pin functions
// - Early request drop aborts, ready low
// - Mode 0 pulse before request re-alarms
module abs_readout_device (
  input  wire logic        clk,
  input  wire logic        reset_n,
  abs_readout_if.device    link,
  input  wire logic        absEnable,
  input  wire logic        resetMode,
  input  wire logic        positionLost,
  input  wire logic        homeLatched,
  input  wire logic        alarmClearRaw,
  input  wire logic        homePreset,
  input  wire logic        pulseIn,
  input  wire logic        pulseDir,
  input  wire logic        overflowAlarm,
  input  wire logic [7:0]  alarmCode,
  input  wire logic        readyNormal,
  input  wire logic        torqueLimitNormal,
  input  wire logic        zeroSpeedNormal,
  input  wire logic [2:0]  alarmBitsNormal,
  output logic             absAlarm_q,
  output logic             pulseEnable_q,
  output logic [31:0]      position_q,
  output logic             alarmClearOut_q,
  output logic             deviationClearOut_q,
  output logic             torque_limit_reached_out_q,
  output logic             zero_speed_out_q,
  output logic             alarm_code_bit0_out_q,
  output logic             alarm_code_bit1_out_q,
  output logic             alarm_code_bit2_out_q,
  output logic             readoutBusy_q
);
  typedef enum logic [2:0] {IDLE, LOAD, READY, WAIT_LOW, DONE} tx_state_t;

  // ==========================================================
  // Input synchronisers and glitch filters
  logic [1:0] reqSync_q, ckSync_q, clrSync_q, presetSync_q, pulseSync_q, dirSync_q;
  logic [abs_readout_pkg::FILTER_CNT_W-1:0] reqCnt_q, ckCnt_q;
  logic reqF_q, ckF_q, reqFPrev_q, clrPrev_q, pulsePrev_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reqSync_q    <= 2'h0;
      ckSync_q     <= 2'h0;
      clrSync_q    <= 2'h0;
      presetSync_q <= 2'h0;
      pulseSync_q  <= 2'h0;
      dirSync_q    <= 2'h0;
    end else begin
      reqSync_q    <= {reqSync_q[0], link.positionRequest};
      ckSync_q     <= {ckSync_q[0], link.handshakeClock};
      clrSync_q    <= {clrSync_q[0], alarmClearRaw};
      presetSync_q <= {presetSync_q[0], homePreset};
      pulseSync_q  <= {pulseSync_q[0], pulseIn};
      dirSync_q    <= {dirSync_q[0], pulseDir};
    end
  end

  function automatic logic [abs_readout_pkg::FILTER_CNT_W-1:0] filtStep(
      input logic [abs_readout_pkg::FILTER_CNT_W-1:0] cnt, input logic raw, input logic cur);
    logic [abs_readout_pkg::FILTER_CNT_W-1:0] r;
    r = '0;
    if (raw != cur) begin
      r = cnt + 1'b1;
    end
    return r;
  endfunction

  wire [abs_readout_pkg::FILTER_CNT_W-1:0] reqCnt_d = filtStep(reqCnt_q, reqSync_q[1], reqF_q);
  wire [abs_readout_pkg::FILTER_CNT_W-1:0] ckCnt_d  = filtStep(ckCnt_q, ckSync_q[1], ckF_q);
  wire reqFlip = (reqCnt_d == abs_readout_pkg::FILTER_CNT_W'(abs_readout_pkg::FILTER_LEN));
  wire ckFlip  = (ckCnt_d == abs_readout_pkg::FILTER_CNT_W'(abs_readout_pkg::FILTER_LEN));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reqCnt_q    <= '0;
      ckCnt_q     <= '0;
      reqF_q      <= 1'b0;
      ckF_q       <= 1'b0;
      reqFPrev_q  <= 1'b0;
      clrPrev_q   <= 1'b0;
      pulsePrev_q <= 1'b0;
    end else begin
      reqCnt_q    <= reqFlip ? '0 : reqCnt_d;
      ckCnt_q     <= ckFlip ? '0 : ckCnt_d;
      reqF_q      <= reqFlip ? ~reqF_q : reqF_q;
      ckF_q       <= ckFlip ? ~ckF_q : ckF_q;
      reqFPrev_q  <= reqF_q;
      clrPrev_q   <= clrSync_q[1];
      pulsePrev_q <= pulseSync_q[1];
    end
  end

  wire reqRise    = reqF_q & ~reqFPrev_q;
  wire readoutOn  = reqF_q & absEnable;
  wire clrFall    = clrPrev_q & ~clrSync_q[1] & ~readoutOn;
  wire pulseEdge  = pulseSync_q[1] & ~pulsePrev_q;

  // ==========================================================
  // Absolute position recovery
  logic       started_q, clearedNoHome_q;
  wire        reAlarm   = clearedNoHome_q & ~pulseEnable_q & pulseEdge
                          & (resetMode == abs_readout_pkg::RESET_MODE_REQ);
  wire        homeSet   = presetSync_q[1] & absAlarm_q == 1'b0 | presetSync_q[1] & clearedNoHome_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      started_q       <= 1'b0;
      absAlarm_q      <= 1'b0;
      clearedNoHome_q <= 1'b0;
      pulseEnable_q   <= 1'b0;
      position_q      <= 32'h0000_0000;
    end else begin
      started_q <= 1'b1;
      if (!started_q) begin
        absAlarm_q    <= absEnable & (positionLost | ~homeLatched);
        pulseEnable_q <= ~(absEnable & (positionLost | ~homeLatched));
      end else if (reAlarm || positionLost) begin
        absAlarm_q      <= 1'b1;
        clearedNoHome_q <= 1'b0;
        pulseEnable_q   <= 1'b0;
      end else if (clrFall && absAlarm_q && !clearedNoHome_q) begin
        clearedNoHome_q <= 1'b1;
        position_q      <= 32'h0000_0000;
        pulseEnable_q   <= (resetMode == abs_readout_pkg::RESET_MODE_NOW);
      end else if (homeSet) begin
        absAlarm_q      <= 1'b0;
        clearedNoHome_q <= 1'b0;
        position_q      <= 32'h0000_0000;
        pulseEnable_q   <= 1'b1;
      end else begin
        if (clearedNoHome_q && reqRise) begin
          pulseEnable_q <= 1'b1;
        end
        if (pulseEdge && pulseEnable_q) begin
          position_q <= dirSync_q[1] ? position_q - 32'h0000_0001 : position_q + 32'h0000_0001;
        end
      end
    end
  end

  // ==========================================================
  // Frame builder and pair sender
  wire [7:0]  statusByte = overflowAlarm ? abs_readout_pkg::STATUS_OVERFLOW : 8'h00;
  wire [7:0]  checkSum   = position_q[31:24] + position_q[23:16] + position_q[15:8]
                           + position_q[7:0] + statusByte + alarmCode;
  wire [55:0] frame      = {position_q, statusByte, alarmCode, checkSum};

  tx_state_t                              state_q;
  logic [55:0]                            shift_q;
  logic [abs_readout_pkg::PAIR_CNT_W-1:0] pairs_q;
  logic                                   readyPin_q, lowPin_q, highPin_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= IDLE;
      shift_q    <= '0;
      pairs_q    <= '0;
      readyPin_q <= 1'b0;
      lowPin_q   <= 1'b0;
      highPin_q  <= 1'b0;
    end else if (!readoutOn) begin
      state_q    <= IDLE;
      readyPin_q <= 1'b0;
    end else begin
      case (state_q)
        IDLE: begin
          state_q <= LOAD;
        end
        LOAD: begin
          shift_q    <= frame;
          pairs_q    <= '0;
          readyPin_q <= 1'b1;
          state_q    <= READY;
        end
        READY: begin
          if (ckF_q) begin
            lowPin_q   <= shift_q[54];
            highPin_q  <= shift_q[55];
            shift_q    <= {shift_q[53:0], 2'b00};
            pairs_q    <= pairs_q + 1'b1;
            readyPin_q <= 1'b0;
            state_q    <= WAIT_LOW;
          end
        end
        WAIT_LOW: begin
          if (!ckF_q) begin
            if (pairs_q == abs_readout_pkg::PAIR_CNT_W'(abs_readout_pkg::PAIR_COUNT)) begin
              state_q <= DONE;
            end else begin
              readyPin_q <= 1'b1;
              state_q    <= READY;
            end
          end
        end
        default: begin
          state_q <= DONE;
        end
      endcase
    end
  end

  // ==========================================================
  // Shared pin multiplexing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link.dataReady             <= 1'b0;
      link.dataLow               <= 1'b0;
      link.dataHigh              <= 1'b0;
      alarmClearOut_q            <= 1'b0;
      deviationClearOut_q        <= 1'b0;
      torque_limit_reached_out_q <= 1'b0;
      zero_speed_out_q           <= 1'b0;
      alarm_code_bit0_out_q      <= 1'b0;
      alarm_code_bit1_out_q      <= 1'b0;
      alarm_code_bit2_out_q      <= 1'b0;
      readoutBusy_q              <= 1'b0;
    end else begin
      readoutBusy_q              <= readoutOn;
      link.dataReady             <= readoutOn ? readyPin_q : readyNormal;
      link.dataLow               <= readoutOn ? lowPin_q : torqueLimitNormal;
      link.dataHigh              <= readoutOn ? highPin_q : zeroSpeedNormal;
      alarmClearOut_q            <= ~readoutOn & clrSync_q[1];
      deviationClearOut_q        <= ~readoutOn & clrSync_q[1];
      torque_limit_reached_out_q <= ~readoutOn & torqueLimitNormal;
      zero_speed_out_q           <= ~readoutOn & zeroSpeedNormal;
      alarm_code_bit0_out_q      <= ~readoutOn & alarmBitsNormal[0];
      alarm_code_bit1_out_q      <= ~readoutOn & alarmBitsNormal[1];
      alarm_code_bit2_out_q      <= ~readoutOn & alarmBitsNormal[2];
    end
  end
endmodule

// *** rtl/abs_readout_host.sv ***
// Controller end: requests a frame and collects it two bits per handshake
`timescale 1ns/1ps
module abs_readout_host (
  input  wire logic        clk,
  input  wire logic        reset_n,
  abs_readout_if.host      link,
  input  wire logic        start,
  output logic [55:0]      frame_q,
  output logic             frameValid_q,
  output logic             checksumOk_q,
  output logic             busy_q
);
  typedef enum logic [2:0] {H_IDLE, H_WAIT_RDY, H_CK_HIGH, H_WAIT_DROP, H_CK_LOW, H_END} host_state_t;

  // ==========================================================
  // Pin synchronisers and tick divider
  logic [1:0] rdySync_q, lowSync_q, highSync_q;
  logic [abs_readout_pkg::HOST_DIV_W-1:0] div_q;
  wire tick = (div_q == abs_readout_pkg::HOST_DIV_LAST);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdySync_q  <= 2'h0;
      lowSync_q  <= 2'h0;
      highSync_q <= 2'h0;
      div_q      <= '0;
    end else begin
      rdySync_q  <= {rdySync_q[0], link.dataReady};
      lowSync_q  <= {lowSync_q[0], link.dataLow};
      highSync_q <= {highSync_q[0], link.dataHigh};
      div_q      <= tick ? '0 : div_q + 1'b1;
    end
  end

  // ==========================================================
  // Handshake sequencer
  host_state_t                      state_q;
  logic [abs_readout_pkg::BIT_CNT_W-1:0] bits_q;
  logic [55:0]                      shift_q;
  wire  [55:0]                      shiftNext = {shift_q[53:0], highSync_q[1], lowSync_q[1]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q              <= H_IDLE;
      bits_q               <= '0;
      shift_q              <= '0;
      frame_q              <= '0;
      frameValid_q         <= 1'b0;
      checksumOk_q         <= 1'b0;
      busy_q               <= 1'b0;
      link.positionRequest <= 1'b0;
      link.handshakeClock  <= 1'b0;
    end else begin
      frameValid_q <= 1'b0;
      if (tick) begin
        case (state_q)
          H_IDLE: begin
            if (start) begin
              link.positionRequest <= 1'b1;
              bits_q               <= '0;
              busy_q               <= 1'b1;
              state_q              <= H_WAIT_RDY;
            end
          end
          H_WAIT_RDY: begin
            if (rdySync_q[1]) begin
              link.handshakeClock <= 1'b1;
              state_q             <= H_WAIT_DROP;
            end
          end
          H_WAIT_DROP: begin
            if (!rdySync_q[1]) begin
              shift_q <= shiftNext;
              bits_q  <= bits_q + 6'h02;
              state_q <= H_CK_LOW;
            end
          end
          H_CK_LOW: begin
            link.handshakeClock <= 1'b0;
            state_q <= (bits_q == abs_readout_pkg::BIT_CNT_W'(abs_readout_pkg::FRAME_BITS)) ? H_END : H_WAIT_RDY;
          end
          H_END: begin
            link.positionRequest <= 1'b0;
            frame_q              <= shift_q;
            checksumOk_q         <= (shift_q[55:48] + shift_q[47:40] + shift_q[39:32] + shift_q[31:24]
                                     + shift_q[23:16] + shift_q[15:8]) == shift_q[7:0];
            frameValid_q         <= 1'b1;
            busy_q               <= 1'b0;
            state_q              <= H_IDLE;
          end
          default: begin
            state_q <= H_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// *** verif/abs_readout_checker.sv ***
// Concurrent checks on the readout link between the device end and the controller end
`timescale 1ns/1ps
module abs_readout_checker (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic absEnable,
  input  wire logic positionRequest,
  input  wire logic handshakeClock,
  input  wire logic dataReady,
  input  wire logic dataLow,
  input  wire logic dataHigh
);
  // ==========================================================
  // Helper state: request age, pairs taken, received frame
  logic [3:0]  reqAge_q;
  logic [3:0]  reqAge_d;
  logic [4:0]  pairCount_q;
  logic [4:0]  pairCount_d;
  logic [55:0] shift_q;
  logic [55:0] shift_d;
  logic        lastReady_q;
  logic [7:0]  byteSum;
  wire         reqSettled;
  wire         pairTaken;

  // Pins are only trusted once the request has stood long enough to be filtered
  assign reqSettled  = (reqAge_q == 4'hf);
  assign pairTaken   = reqSettled & lastReady_q & ~dataReady;
  assign reqAge_d    = !positionRequest ? 4'h0 : (reqSettled ? reqAge_q : reqAge_q + 4'h1);
  assign pairCount_d = !positionRequest ? 5'h00 : (pairTaken ? pairCount_q + 5'h01 : pairCount_q);
  assign shift_d     = pairTaken ? {shift_q[53:0], dataHigh, dataLow} : shift_q;
  assign byteSum     = shift_q[55:48] + shift_q[47:40] + shift_q[39:32] + shift_q[31:24] + shift_q[23:16]
                       + shift_q[15:8];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reqAge_q    <= 4'h0;
      pairCount_q <= 5'h00;
      shift_q     <= 56'h0;
      lastReady_q <= 1'b0;
    end else begin
      reqAge_q    <= reqAge_d;
      pairCount_q <= pairCount_d;
      shift_q     <= shift_d;
      lastReady_q <= dataReady;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ready_on_request_a: assert property ($rose(positionRequest) && absEnable |-> ##[1:60] dataReady)
    else $error("data ready missing after request rise");
  ready_drops_a: assert property ($rose(handshakeClock) && positionRequest |-> ##[1:20] !dataReady)
    else $error("data ready not dropped after handshake clock high");
  pair_stable_a: assert property (positionRequest && reqSettled && $changed({dataHigh, dataLow})
    |-> $fell(dataReady))
    else $error("data pair changed outside a ready drop");
  ready_returns_a: assert property ($fell(handshakeClock) && positionRequest && pairCount_q < 5'h1c
    |-> ##[1:20] dataReady)
    else $error("data ready not raised after handshake clock low");
  frame_end_a: assert property (positionRequest && pairCount_q == 5'h1c && !handshakeClock |-> !dataReady)
    else $error("data ready raised after the last pair");
  clock_after_ready_a: assert property ($rose(handshakeClock) |-> dataReady)
    else $error("handshake clock raised without data ready");
  clock_fall_a: assert property ($fell(handshakeClock) |-> !dataReady)
    else $error("handshake clock lowered while data ready high");
  request_drop_a: assert property ($fell(positionRequest) |-> pairCount_q == 5'h1c)
    else $error("request dropped before the whole frame");
  checksum_sum_a: assert property (pairCount_q == 5'h1c |-> shift_q[7:0] == byteSum)
    else $error("checksum byte does not match the six-byte sum");

  cover property (pairTaken && pairCount_q == 5'h00);
  cover property (pairCount_q == 5'h1c && shift_q[55]);
  cover property ($fell(positionRequest) && pairCount_q == 5'h1c);
endmodule

// *** verif/test_absolute_position_readout.sv ***
// Self-checking bench joining the device end and the controller end over the link
`timescale 1ns/1ps
module test_absolute_position_readout;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk, devReset_n, hostReset_n, start;
  logic        absEnable, resetMode, positionLost, homeLatched, alarmClearRaw, homePreset;
  logic        pulseIn, pulseDir, overflowAlarm, readyNormal, torqueLimitNormal, zeroSpeedNormal;
  logic [7:0]  alarmCode;
  logic [2:0]  alarmBitsNormal;
  logic        absAlarm_q, pulseEnable_q, alarmClearOut_q, deviationClearOut_q, readoutBusy_q;
  logic        torque_limit_reached_out_q, zero_speed_out_q;
  logic        alarm_code_bit0_out_q, alarm_code_bit1_out_q, alarm_code_bit2_out_q;
  logic [31:0] position_q;
  logic [55:0] frame_q;
  logic        frameValid_q, checksumOk_q, busy_q;
  int          badCount;
  int          testsRun;
  abs_readout_if link ();
  wire  [7:0]  pinsSeen   = {link.dataReady, link.dataLow, link.dataHigh, torque_limit_reached_out_q,
                             zero_speed_out_q, alarm_code_bit2_out_q, alarm_code_bit1_out_q, alarm_code_bit0_out_q};
  wire  [7:0]  pinsNormal = {readyNormal, torqueLimitNormal, zeroSpeedNormal, torqueLimitNormal, zeroSpeedNormal,
                             alarmBitsNormal};
  wire  [6:0]  gatedOuts  = {torque_limit_reached_out_q, zero_speed_out_q, alarm_code_bit2_out_q,
                             alarm_code_bit1_out_q, alarm_code_bit0_out_q, alarmClearOut_q, deviationClearOut_q};

  abs_readout_device abs_readout_device_i (.clk, .reset_n(devReset_n), .link(link), .absEnable, .resetMode,
    .positionLost, .homeLatched, .alarmClearRaw, .homePreset, .pulseIn, .pulseDir, .overflowAlarm, .alarmCode,
    .readyNormal, .torqueLimitNormal, .zeroSpeedNormal, .alarmBitsNormal, .absAlarm_q, .pulseEnable_q, .position_q,
    .alarmClearOut_q, .deviationClearOut_q, .torque_limit_reached_out_q, .zero_speed_out_q, .alarm_code_bit0_out_q,
    .alarm_code_bit1_out_q, .alarm_code_bit2_out_q, .readoutBusy_q);
  abs_readout_host abs_readout_host_i (.clk, .reset_n(hostReset_n), .link(link), .start, .frame_q, .frameValid_q,
    .checksumOk_q, .busy_q);
  abs_readout_checker abs_readout_checker_i (.clk, .reset_n(devReset_n & hostReset_n), .absEnable,
    .positionRequest(link.positionRequest), .handshakeClock(link.handshakeClock), .dataReady(link.dataReady),
    .dataLow(link.dataLow), .dataHigh(link.dataHigh));

  // ==========================================================
  // Clock, watchdog and helpers
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    timeOut();
  end
  task automatic reportAndStop();
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timeOut();
    badCount++;
    reportAndStop();
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    testsRun++;
    if (seen !== want) begin
      badCount++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic clearAlarm();
    @(posedge clk);
    alarmClearRaw <= 1'b1;
    tick(10);
    alarmClearRaw <= 1'b0;
    tick(10);
  endtask
  task automatic setHome();
    @(posedge clk);
    homePreset <= 1'b1;
    tick(10);
    homePreset <= 1'b0;
    tick(10);
  endtask
  task automatic pulse(input int n, input logic dir);
    @(posedge clk);
    pulseDir <= dir;
    tick(4);
    for (int i = 0; i < n; i++) begin
      pulseIn <= 1'b1;
      tick(8);
      pulseIn <= 1'b0;
      tick(8);
    end
  endtask
  task automatic normalPins();
    @(negedge clk);
    check(pinsSeen, pinsNormal);
  endtask
  function automatic logic [55:0] makeFrame(input logic [31:0] pos, input logic [7:0] st, input logic [7:0] code);
    logic [7:0] sum;
    sum = pos[31:24] + pos[23:16] + pos[15:8] + pos[7:0] + st + code;
    return {pos, st, code, sum};
  endfunction
  task automatic readFrame(input logic [55:0] want);
    int n;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    @(negedge clk);
    while (frameValid_q !== 1'b1) begin
      if (n == 20000) timeOut();
      n++;
      @(negedge clk);
    end
    check(frame_q, want);
    check(checksumOk_q, 1'b1);
    @(posedge clk);
    start <= 1'b0;
    tick(40);
    normalPins();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {devReset_n, hostReset_n, start, resetMode, homeLatched, alarmClearRaw, homePreset} = 7'h00;
    {pulseIn, pulseDir, readyNormal} = 3'h0;
    {absEnable, positionLost, overflowAlarm, torqueLimitNormal, zeroSpeedNormal} = 5'h1f;
    alarmCode = 8'h30;
    alarmBitsNormal = 3'h5;
    badCount = 0;
    testsRun = 0;
    tick(16);
    devReset_n <= 1'b1;
    hostReset_n <= 1'b1;
    tick(4);
    positionLost <= 1'b0;
    @(negedge clk);
    check(absAlarm_q, 1'b1);
    clearAlarm();
    @(negedge clk);
    check(position_q, 32'h0000_0000);
    check(absAlarm_q, 1'b1);
    check(pulseEnable_q, 1'b0);
    pulse(1, 1'b0);
    @(negedge clk);
    check(absAlarm_q, 1'b1);
    check(position_q, 32'h0000_0000);
    clearAlarm();
    normalPins();
    readFrame(makeFrame(32'h0000_0000, 8'h01, 8'h30));
    check(pulseEnable_q, 1'b1);
    check(absAlarm_q, 1'b1);
    setHome();
    @(negedge clk);
    check(absAlarm_q, 1'b0);
    pulse(3, 1'b1);
    overflowAlarm <= 1'b0;
    alarmCode <= 8'ha5;
    readFrame(makeFrame(32'hffff_fffd, 8'h00, 8'ha5));
    // Abort in mid-frame with the alarm clear input toggled meanwhile
    @(posedge clk);
    start <= 1'b1;
    tick(150);
    alarmClearRaw <= 1'b1;
    tick(20);
    @(negedge clk);
    check(readoutBusy_q, 1'b1);
    check(busy_q, 1'b1);
    check(gatedOuts, 7'h00);
    @(posedge clk);
    alarmClearRaw <= 1'b0;
    start <= 1'b0;
    hostReset_n <= 1'b0;
    tick(30);
    @(negedge clk);
    check(readoutBusy_q, 1'b0);
    check(link.dataReady, 1'b0);
    normalPins();
    @(posedge clk);
    hostReset_n <= 1'b1;
    absEnable <= 1'b0;
    start <= 1'b1;
    tick(40);
    @(negedge clk);
    check(readoutBusy_q, 1'b0);
    check(link.dataLow, torqueLimitNormal);
    @(posedge clk);
    hostReset_n <= 1'b0;
    start <= 1'b0;
    absEnable <= 1'b1;
    tick(4);
    hostReset_n <= 1'b1;
    // Power cycles: a latched home keeps the alarm off, a missing home raises it
    homeLatched <= 1'b1;
    devReset_n <= 1'b0;
    tick(4);
    devReset_n <= 1'b1;
    tick(4);
    @(negedge clk);
    check(absAlarm_q, 1'b0);
    clearAlarm();
    homeLatched <= 1'b0;
    resetMode <= 1'b1;
    devReset_n <= 1'b0;
    tick(4);
    devReset_n <= 1'b1;
    tick(4);
    @(negedge clk);
    check(absAlarm_q, 1'b1);
    check(pulseEnable_q, 1'b0);
    clearAlarm();
    @(negedge clk);
    check(pulseEnable_q, 1'b1);
    check(position_q, 32'h0000_0000);
    reportAndStop();
  end
endmodule
